// ---- src/cic_defines.svh ----
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

// ----------------------------------------------------------------------
// register select codes on the byte-wide processor port
// ----------------------------------------------------------------------
`define CIC_SEL_CNT_L     4'h0
`define CIC_SEL_CNT_H     4'h1
`define CIC_SEL_CAP_L     4'h2
`define CIC_SEL_CAP_H     4'h3
`define CIC_SEL_CMPA_L    4'h4
`define CIC_SEL_CMPA_H    4'h5
`define CIC_SEL_CTRL_A    4'h6
`define CIC_SEL_CTRL_B    4'h7
`define CIC_SEL_FLAGS     4'h8
`define CIC_SEL_IRQ_EN    4'h9
`define CIC_SEL_CMP_CS    4'hA

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CIC_A_WGM_MSB     1
`define CIC_A_WGM_LSB     0
`define CIC_B_NF_EN       7
`define CIC_B_EDGE        6
`define CIC_B_WGM_MSB     4
`define CIC_B_WGM_LSB     3
`define CIC_B_CS_MSB      2
`define CIC_B_CS_LSB      0
`define CIC_FLAG_CAP      5
`define CIC_FLAG_OVF      2
`define CIC_ACS_CAPSEL    3

// ----------------------------------------------------------------------
// waveform modes
// ----------------------------------------------------------------------
`define CIC_WGM_NORMAL    4'h0
`define CIC_WGM_PC8       4'h1
`define CIC_WGM_PC9       4'h2
`define CIC_WGM_PC10      4'h3
`define CIC_WGM_CTC_A     4'h4
`define CIC_WGM_FAST8     4'h5
`define CIC_WGM_FAST9     4'h6
`define CIC_WGM_FAST10    4'h7
`define CIC_WGM_PFC_ICR   4'h8
`define CIC_WGM_PFC_A     4'h9
`define CIC_WGM_PC_ICR    4'hA
`define CIC_WGM_PC_A      4'hB
`define CIC_WGM_CTC_ICR   4'hC
`define CIC_WGM_FAST_ICR  4'hE
`define CIC_WGM_FAST_A    4'hF

// ----------------------------------------------------------------------
// counter values, clock sources, prescaler taps, reset values
// ----------------------------------------------------------------------
`define CIC_BOTTOM        16'h0000
`define CIC_ONE           16'h0001
`define CIC_MAX           16'hFFFF
`define CIC_TOP8          16'h00FF
`define CIC_TOP9          16'h01FF
`define CIC_TOP10         16'h03FF
`define CIC_CS_STOP       3'h0
`define CIC_CS_DIV1       3'h1
`define CIC_CS_DIV8       3'h2
`define CIC_CS_DIV64      3'h3
`define CIC_CS_DIV256     3'h4
`define CIC_CS_DIV1024    3'h5
`define CIC_CS_EXT_FALL   3'h6
`define CIC_CS_EXT_RISE   3'h7
`define CIC_PRE_W         10
`define CIC_TAP8          2
`define CIC_TAP64         5
`define CIC_TAP256        7
`define CIC_TAP1024       9
`define CIC_RST8          8'h00
`define CIC_RST16         16'h0000
`define CIC_RST_PRE       10'h000

`endif

// ---- src/cic_pkg.sv ----
package cic_pkg;

  // ----------------------------------------------------------------------
  // processor access and interrupt acknowledge carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sel;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } cic_cpu_req_t;

  typedef struct packed {
    logic cap;
    logic ovf;
  } cic_irq_ack_t;

  // count direction for dual-slope modes
  typedef enum logic {CIC_UP, CIC_DOWN} cic_dir_t;

endpackage

// ---- src/cic_timer.sv ----
// Behaviour
// - each tick clears, increments or decrements counter
// - counter low read loads high into latch
// - counter low write loads latch plus byte
// - source select zero stops ticks, access works
// - processor write beats clear or count
// - four-bit mode field sets counting sequence
// - overflow flag set per mode, may interrupt
// - qualifying edge copies counter into capture
// - capture flag set with the copy
// - flag interrupts if enabled; ack or one clears
// - capture low read loads high into latch
// - capture writable only in capture-top modes
// - comparator select uses comparator as trigger
// - filter changes only after four equal samples
// - filter enable in control B, system clock
// - capture-top modes gate off capture events, filter runs on
// - pin driven by own port output captures too
// - bottom, max and top values per mode
`include "cic_defines.svh"

module cic_timer
  import cic_pkg::*;
#(
  parameter int FILT_LEN = 4
) (
  input  logic         clk,
  input  logic         resetn,
  input  cic_cpu_req_t cpu_req,
  output logic [7:0]   cpu_rdata,
  input  logic         capture_pin,
  input  logic         comparator_output,
  input  logic         ext_tick_pin,
  input  cic_irq_ack_t irq_ack,
  output logic         capture_irq,
  output logic         overflow_irq
);

  // ----------------------------------------------------------------------
  // mode decode helpers
  // ----------------------------------------------------------------------

  // modes that take the capture register as top
  function automatic logic icr_is_top(input logic [3:0] m);
    return (m == `CIC_WGM_PFC_ICR) || (m == `CIC_WGM_PC_ICR) ||
           (m == `CIC_WGM_CTC_ICR) || (m == `CIC_WGM_FAST_ICR);
  endfunction

  // up/down counting modes
  function automatic logic is_dual(input logic [3:0] m);
    return (m == `CIC_WGM_PC8) || (m == `CIC_WGM_PC9) || (m == `CIC_WGM_PC10) ||
           (m == `CIC_WGM_PFC_ICR) || (m == `CIC_WGM_PFC_A) ||
           (m == `CIC_WGM_PC_ICR) || (m == `CIC_WGM_PC_A);
  endfunction

  // single-slope modes that wrap at top and flag there
  function automatic logic is_fast(input logic [3:0] m);
    return (m == `CIC_WGM_FAST8) || (m == `CIC_WGM_FAST9) ||
           (m == `CIC_WGM_FAST10) || (m == `CIC_WGM_FAST_ICR) ||
           (m == `CIC_WGM_FAST_A);
  endfunction

  // top value of the count sequence
  function automatic logic [15:0] top_of(input logic [3:0]  m,
                                         input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    case (m)
      `CIC_WGM_PC8, `CIC_WGM_FAST8:                        return `CIC_TOP8;
      `CIC_WGM_PC9, `CIC_WGM_FAST9:                        return `CIC_TOP9;
      `CIC_WGM_PC10, `CIC_WGM_FAST10:                      return `CIC_TOP10;
      `CIC_WGM_CTC_A, `CIC_WGM_PFC_A, `CIC_WGM_PC_A,
      `CIC_WGM_FAST_A:                                     return cmpa;
      `CIC_WGM_PFC_ICR, `CIC_WGM_PC_ICR, `CIC_WGM_CTC_ICR,
      `CIC_WGM_FAST_ICR:                                   return cap;
      default:                                             return `CIC_MAX;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0]           count_r;
  logic [15:0]           cnt_nxt;
  cic_dir_t              dir_r;
  cic_dir_t              dir_nxt;
  logic [7:0]            temp_r;
  logic [7:0]            temp_nxt;
  logic [15:0]           capture_r;
  logic [15:0]           cmpa_r;
  logic [7:0]            ctrl_a_r;
  logic [7:0]            ctrl_b_r;
  logic [7:0]            irq_en_r;
  logic [7:0]            acs_r;
  logic                  cap_flag_r;
  logic                  ovf_flag_r;
  logic [`CIC_PRE_W-1:0] pre_r;
  logic [2:0]            pin_s_r;
  logic [2:0]            cmp_s_r;
  logic [2:0]            ext_s_r;
  logic                  pin_lvl_r;
  logic                  cmp_lvl_r;
  logic                  ext_lvl_r;
  logic                  ext_prev_r;
  logic [FILT_LEN-1:0]   samp_r;
  logic                  filt_q_r;
  logic                  filt_prev_r;
  logic                  ovf_set;

  // ----------------------------------------------------------------------
  // processor access decode
  // ----------------------------------------------------------------------
  wire       rd        = cpu_req.rd;
  wire       wr        = cpu_req.wr;
  wire [3:0] sel       = cpu_req.sel;
  wire [7:0] wdata     = cpu_req.wdata;
  wire       wr_cnt_l  = wr && (sel == `CIC_SEL_CNT_L);
  wire       wr_cap_l  = wr && (sel == `CIC_SEL_CAP_L);
  wire       wr_cmpa_l = wr && (sel == `CIC_SEL_CMPA_L);
  wire       wr_high   = wr && ((sel == `CIC_SEL_CNT_H) || (sel == `CIC_SEL_CAP_H) ||
                                (sel == `CIC_SEL_CMPA_H));
  wire       rd_cnt_l  = rd && (sel == `CIC_SEL_CNT_L);
  wire       rd_cap_l  = rd && (sel == `CIC_SEL_CAP_L);
  wire       wr_flags  = wr && (sel == `CIC_SEL_FLAGS);

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  wire [3:0] wgm      = {ctrl_b_r[`CIC_B_WGM_MSB:`CIC_B_WGM_LSB],
                         ctrl_a_r[`CIC_A_WGM_MSB:`CIC_A_WGM_LSB]};
  wire [2:0] cs       = ctrl_b_r[`CIC_B_CS_MSB:`CIC_B_CS_LSB];
  wire       nf_en    = ctrl_b_r[`CIC_B_NF_EN];
  wire       edge_up  = ctrl_b_r[`CIC_B_EDGE];
  wire       cap_sel  = acs_r[`CIC_ACS_CAPSEL];
  wire       icr_top  = icr_is_top(wgm);
  wire [15:0] top_val = top_of(wgm, cmpa_r, capture_r);

  // ----------------------------------------------------------------------
  // timer tick: prescaler taps or synchronised external pin
  // ----------------------------------------------------------------------
  wire ext_rise = ext_lvl_r & ~ext_prev_r;
  wire ext_fall = ~ext_lvl_r & ext_prev_r;
  wire tick = ((cs == `CIC_CS_DIV1)) |
              ((cs == `CIC_CS_DIV8)     & (&pre_r[`CIC_TAP8:0])) |
              ((cs == `CIC_CS_DIV64)    & (&pre_r[`CIC_TAP64:0])) |
              ((cs == `CIC_CS_DIV256)   & (&pre_r[`CIC_TAP256:0])) |
              ((cs == `CIC_CS_DIV1024)  & (&pre_r[`CIC_TAP1024:0])) |
              ((cs == `CIC_CS_EXT_FALL) & ext_fall) |
              ((cs == `CIC_CS_EXT_RISE) & ext_rise);

  // free-running prescaler
  always_ff @(posedge clk) begin
    if (!resetn) pre_r <= `CIC_RST_PRE;
    else         pre_r <= pre_r + {{(`CIC_PRE_W-1){1'b0}}, 1'b1};
  end

  // ----------------------------------------------------------------------
  // counter next value and overflow point
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_nxt = count_r;
    dir_nxt = dir_r;
    ovf_set = 1'b0;
    if (wr_cnt_l) begin
      cnt_nxt = {temp_r, wdata};
    end else if (tick) begin
      if (is_dual(wgm)) begin
        if (dir_r == CIC_UP) begin
          if (count_r == top_val) begin
            dir_nxt = CIC_DOWN;
            cnt_nxt = count_r - `CIC_ONE;
          end else begin
            cnt_nxt = count_r + `CIC_ONE;
          end
        end else begin
          if (count_r == `CIC_BOTTOM) begin
            dir_nxt = CIC_UP;
            cnt_nxt = `CIC_ONE;
          end else begin
            cnt_nxt = count_r - `CIC_ONE;
            if (count_r == `CIC_ONE) begin
              dir_nxt = CIC_UP;
              ovf_set = 1'b1;
            end
          end
        end
      end else if (is_fast(wgm)) begin
        cnt_nxt = (count_r == top_val) ? `CIC_BOTTOM : count_r + `CIC_ONE;
        ovf_set = (count_r == top_val);
      end else begin
        cnt_nxt = ((wgm != `CIC_WGM_NORMAL) && (count_r == top_val)) ?
                  `CIC_BOTTOM : count_r + `CIC_ONE;
        ovf_set = (count_r == `CIC_MAX);
      end
    end
  end

  // counter and direction registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_r <= `CIC_RST16;
      dir_r   <= CIC_UP;
    end else begin
      count_r <= cnt_nxt;
      dir_r   <= dir_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // shared high-byte latch
  // ----------------------------------------------------------------------
  assign temp_nxt = rd_cnt_l ? count_r[15:8] :
                    rd_cap_l ? capture_r[15:8] :
                    wr_high  ? wdata : temp_r;

  always_ff @(posedge clk) begin
    if (!resetn) temp_r <= `CIC_RST8;
    else         temp_r <= temp_nxt;
  end

  // ----------------------------------------------------------------------
  // capture source: synchronise, qualify, select, filter, edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s_r <= 3'h0;
      cmp_s_r <= 3'h0;
      ext_s_r <= 3'h0;
    end else begin
      pin_s_r <= {pin_s_r[1:0], capture_pin};
      cmp_s_r <= {cmp_s_r[1:0], comparator_output};
      ext_s_r <= {ext_s_r[1:0], ext_tick_pin};
    end
  end

  // a level is taken once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_lvl_r  <= 1'b0;
      cmp_lvl_r  <= 1'b0;
      ext_lvl_r  <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      pin_lvl_r  <= (pin_s_r[1] == pin_s_r[2]) ? pin_s_r[2] : pin_lvl_r;
      cmp_lvl_r  <= (cmp_s_r[1] == cmp_s_r[2]) ? cmp_s_r[2] : cmp_lvl_r;
      ext_lvl_r  <= (ext_s_r[1] == ext_s_r[2]) ? ext_s_r[2] : ext_lvl_r;
      ext_prev_r <= ext_lvl_r;
    end
  end

  wire src_lvl  = cap_sel ? cmp_lvl_r : pin_lvl_r;
  wire all_one  = (samp_r == {FILT_LEN{1'b1}});
  wire all_zero = (samp_r == {FILT_LEN{1'b0}});
  wire filt_d   = !nf_en ? src_lvl :
                  all_one ? 1'b1 : all_zero ? 1'b0 : filt_q_r;

  // noise filter on the system clock, not the prescaler
  always_ff @(posedge clk) begin
    if (!resetn) begin
      samp_r      <= {FILT_LEN{1'b0}};
      filt_q_r    <= 1'b0;
      filt_prev_r <= 1'b0;
    end else begin
      samp_r      <= {samp_r[FILT_LEN-2:0], src_lvl};
      filt_q_r    <= filt_d;
      filt_prev_r <= filt_q_r;
    end
  end

  // edge detector, gated off in capture-top modes
  wire rise_seen = filt_q_r & ~filt_prev_r;
  wire fall_seen = ~filt_q_r & filt_prev_r;
  wire cap_event = !icr_top && (edge_up ? rise_seen : fall_seen);

  // ----------------------------------------------------------------------
  // capture and compare registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      capture_r <= `CIC_RST16;
      cmpa_r    <= `CIC_RST16;
    end else begin
      if (wr_cap_l && icr_top) capture_r <= {temp_r, wdata};
      else if (cap_event)      capture_r <= count_r;
      if (wr_cmpa_l)           cmpa_r    <= {temp_r, wdata};
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_a_r <= `CIC_RST8;
      ctrl_b_r <= `CIC_RST8;
      irq_en_r <= `CIC_RST8;
      acs_r    <= `CIC_RST8;
    end else if (wr) begin
      if (sel == `CIC_SEL_CTRL_A) ctrl_a_r <= wdata;
      if (sel == `CIC_SEL_CTRL_B) ctrl_b_r <= wdata;
      if (sel == `CIC_SEL_IRQ_EN) irq_en_r <= wdata;
      if (sel == `CIC_SEL_CMP_CS) acs_r    <= wdata;
    end
  end

  // ----------------------------------------------------------------------
  // flags and interrupt requests; a set beats a clear
  // ----------------------------------------------------------------------
  wire cap_clr = irq_ack.cap | (wr_flags & wdata[`CIC_FLAG_CAP]);
  wire ovf_clr = irq_ack.ovf | (wr_flags & wdata[`CIC_FLAG_OVF]);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_flag_r   <= 1'b0;
      ovf_flag_r   <= 1'b0;
      capture_irq  <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      cap_flag_r   <= cap_event | (cap_flag_r & ~cap_clr);
      ovf_flag_r   <= ovf_set | (ovf_flag_r & ~ovf_clr);
      capture_irq  <= cap_flag_r & irq_en_r[`CIC_FLAG_CAP];
      overflow_irq <= ovf_flag_r & irq_en_r[`CIC_FLAG_OVF];
    end
  end

  // ----------------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------------
  wire [7:0] flags_rd = {2'b00, cap_flag_r, 2'b00, ovf_flag_r, 2'b00};
  wire [7:0] rd_mux =
    (sel == `CIC_SEL_CNT_L)  ? count_r[7:0] :
    (sel == `CIC_SEL_CNT_H)  ? temp_r :
    (sel == `CIC_SEL_CAP_L)  ? capture_r[7:0] :
    (sel == `CIC_SEL_CAP_H)  ? temp_r :
    (sel == `CIC_SEL_CMPA_L) ? cmpa_r[7:0] :
    (sel == `CIC_SEL_CMPA_H) ? cmpa_r[15:8] :
    (sel == `CIC_SEL_CTRL_A) ? ctrl_a_r :
    (sel == `CIC_SEL_CTRL_B) ? ctrl_b_r :
    (sel == `CIC_SEL_FLAGS)  ? flags_rd :
    (sel == `CIC_SEL_IRQ_EN) ? irq_en_r :
    (sel == `CIC_SEL_CMP_CS) ? acs_r : `CIC_RST8;

  always_ff @(posedge clk) begin
    if (!resetn)  cpu_rdata <= `CIC_RST8;
    else if (rd)  cpu_rdata <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  cap_copy_a: assert property (cap_event |=> cap_flag_r &&
                               (capture_r == $past(count_r)))
    else $error("capture did not copy counter with flag");
  cnt_write_a: assert property (wr_cnt_l |=> count_r == {$past(temp_r),
                                $past(wdata)})
    else $error("counter write lost");
  cnt_stop_a: assert property ((cs == `CIC_CS_STOP) && !wr_cnt_l |=>
                               $stable(count_r))
    else $error("counter moved while stopped");
  cnt_up_a: assert property (tick && !wr_cnt_l && (wgm == `CIC_WGM_NORMAL) |=>
                             count_r == $past(count_r) + `CIC_ONE)
    else $error("normal mode did not increment");
  ovf_max_a: assert property (tick && !wr_cnt_l && (wgm == `CIC_WGM_NORMAL) &&
                              (count_r == `CIC_MAX) |=> ovf_flag_r ##1 1)
    else $error("overflow flag missed at max");
  latch_read_a: assert property (rd_cnt_l ##1 (rd && sel == `CIC_SEL_CNT_H)
                                 |=> cpu_rdata == $past(count_r[15:8], 2))
    else $error("high byte read not from latch");
  latch_write_a: assert property (wr_high |=> temp_r == $past(wdata))
    else $error("high write missed the latch");
  cap_guard_a: assert property (wr_cap_l && !icr_top && !cap_event |=>
                                $stable(capture_r))
    else $error("capture written in wrong mode");
  cap_block_a: assert property (icr_top |-> !cap_event)
    else $error("capture fired in capture-top mode");
  filt_agree_a: assert property ($past(nf_en) && $changed(filt_q_r) |->
                                 $past(samp_r) == {FILT_LEN{filt_q_r}})
    else $error("filter changed without agreement");
  cap_irq_a: assert property (cap_flag_r && irq_en_r[`CIC_FLAG_CAP] |=>
                              capture_irq)
    else $error("capture interrupt not raised");
  flag_clear_a: assert property (cap_flag_r && cap_clr && !cap_event |=>
                                 !cap_flag_r)
    else $error("capture flag not cleared");

endmodule // cic_timer

// ---- test/cic_event_src.sv ----
// ----------------------------------------------------------------------
// far-side event source: capture pin and comparator level
// ----------------------------------------------------------------------
module cic_event_src (
  input  logic pin_req,
  input  logic cmp_req,
  output logic capture_pin,
  output logic comparator_output
);
  timeunit 1ns;
  timeprecision 1ns;

  // levels land out of phase with the system clock
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
  end
  always @(pin_req) capture_pin <= #37 pin_req;
  always @(cmp_req) comparator_output <= #61 cmp_req;
endmodule // cic_event_src

// ---- test/counter16_input_capture_bench.sv ----
`include "cic_defines.svh"
module counter16_input_capture_bench
  import cic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         pin_lvl = 1'b0;
  logic         cmp_lvl = 1'b0;
  logic         rd_taken = 1'b0;
  cic_cpu_req_t req = '0;
  cic_irq_ack_t ack = '0;
  logic [7:0]   rdata;
  logic         cap_pin;
  logic         cmp_out;
  logic         cap_irq;
  logic         ovf_irq;
  logic [7:0]   expq[$];
  logic [15:0]  rv;
  int           miscompares = 0;
  int           checked = 0;
  int           seed = 32'h2b569474;

  // ----------------------------------------------------------------------
  // design, far side and clock
  // ----------------------------------------------------------------------
  cic_timer #(.FILT_LEN(4)) i_cic_timer (
    .clk(clk), .resetn(resetn), .cpu_req(req), .cpu_rdata(rdata),
    .capture_pin(cap_pin), .comparator_output(cmp_out), .ext_tick_pin(1'b0),
    .irq_ack(ack), .capture_irq(cap_irq), .overflow_irq(ovf_irq));
  cic_event_src i_cic_event_src (.pin_req(pin_lvl), .cmp_req(cmp_lvl),
    .capture_pin(cap_pin), .comparator_output(cmp_out));
  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic [3:0] sel, logic [7:0] d);
    @(negedge clk);
    req = '{sel: sel, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  // a read notes its expected byte; the monitor compares it
  task automatic rd(logic [3:0] sel, logic [7:0] exp);
    @(negedge clk);
    req.sel = sel;
    req.rd = 1'b1;
    expq.push_back(exp);
    @(negedge clk);
    req.rd = 1'b0;
  endtask
  task automatic ackp(logic cap);
    @(negedge clk);
    ack = {cap, !cap};
    @(negedge clk);
    ack = '0;
  endtask
  // level change, then enough cycles for sync, filter and edge logic
  task automatic pin(logic v);
    @(negedge clk);
    pin_lvl = v;
    idle(14);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // monitor: read data stands one cycle after the read edge
  // ----------------------------------------------------------------------
  always @(posedge clk) rd_taken <= req.rd;
  always @(negedge clk) begin
    if (rd_taken) begin
      check("read data", rdata, expq.pop_front());
    end
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    idle(5);
    rd(`CIC_SEL_CNT_L, 8'h00);
    rd(`CIC_SEL_CNT_H, 8'h00);
    wr(`CIC_SEL_CNT_H, 8'h01);
    wr(`CIC_SEL_CNT_L, 8'hFF);
    wr(`CIC_SEL_CNT_H, 8'h55);
    rd(`CIC_SEL_CNT_L, 8'hFF);
    rd(`CIC_SEL_CNT_H, 8'h01);
    $display("test byte access done");
    wr(`CIC_SEL_CNT_H, 8'hFF);
    wr(`CIC_SEL_CTRL_B, 8'h01);
    wr(`CIC_SEL_CNT_L, 8'hFF);
    wr(`CIC_SEL_CTRL_B, 8'h00);
    rd(`CIC_SEL_CNT_L, 8'h01);
    rd(`CIC_SEL_CNT_H, 8'h00);
    rd(`CIC_SEL_FLAGS, 8'h04);
    wr(`CIC_SEL_IRQ_EN, 8'h04);
    idle(1);
    check("overflow irq", ovf_irq, 1'b1);
    ackp(1'b0);
    idle(1);
    check("overflow irq", ovf_irq, 1'b0);
    $display("test counting done");
    wr(`CIC_SEL_CTRL_B, 8'h40);
    pin(1'b1);
    rd(`CIC_SEL_FLAGS, 8'h20);
    rd(`CIC_SEL_CAP_L, 8'h01);
    rd(`CIC_SEL_CAP_H, 8'h00);
    wr(`CIC_SEL_IRQ_EN, 8'h20);
    idle(1);
    check("capture irq", cap_irq, 1'b1);
    ackp(1'b1);
    idle(1);
    check("capture irq", cap_irq, 1'b0);
    rv = 16'($random(seed));
    wr(`CIC_SEL_CNT_H, rv[15:8]);
    wr(`CIC_SEL_CNT_L, rv[7:0]);
    pin(1'b0);
    rd(`CIC_SEL_FLAGS, 8'h00);
    wr(`CIC_SEL_CTRL_B, 8'h00);
    pin(1'b1);
    pin(1'b0);
    rd(`CIC_SEL_CAP_L, rv[7:0]);
    rd(`CIC_SEL_CAP_H, rv[15:8]);
    wr(`CIC_SEL_FLAGS, 8'h20);
    rd(`CIC_SEL_FLAGS, 8'h00);
    $display("test capture done");
    wr(`CIC_SEL_CTRL_B, 8'hC0);
    @(negedge clk);
    pin_lvl = 1'b1;
    idle(2);
    pin_lvl = 1'b0;
    idle(14);
    rd(`CIC_SEL_FLAGS, 8'h00);
    pin(1'b1);
    rd(`CIC_SEL_FLAGS, 8'h20);
    wr(`CIC_SEL_CMP_CS, 8'h08);
    wr(`CIC_SEL_FLAGS, 8'h20);
    @(negedge clk);
    cmp_lvl = 1'b1;
    idle(14);
    rd(`CIC_SEL_FLAGS, 8'h20);
    wr(`CIC_SEL_FLAGS, 8'h20);
    pin(1'b0);
    pin(1'b1);
    rd(`CIC_SEL_FLAGS, 8'h00);
    $display("test filter and source done");
    wr(`CIC_SEL_CAP_H, 8'hA5);
    wr(`CIC_SEL_CAP_L, 8'h5A);
    rd(`CIC_SEL_CAP_L, rv[7:0]);
    rd(`CIC_SEL_CAP_H, rv[15:8]);
    rv = 16'($random(seed));
    wr(`CIC_SEL_CTRL_B, 8'h18);
    wr(`CIC_SEL_CAP_H, rv[15:8]);
    wr(`CIC_SEL_CAP_L, rv[7:0]);
    @(negedge clk);
    cmp_lvl = 1'b0;
    idle(14);
    rd(`CIC_SEL_FLAGS, 8'h00);
    rd(`CIC_SEL_CAP_L, rv[7:0]);
    rd(`CIC_SEL_CAP_H, rv[15:8]);
    idle(2);
    $display("test capture top done");
    // fast 8-bit mode: wraps at its fixed top and flags there
    wr(`CIC_SEL_CTRL_A, 8'h01);
    wr(`CIC_SEL_CNT_H, 8'h00);
    wr(`CIC_SEL_CNT_L, 8'hFE);
    wr(`CIC_SEL_CTRL_B, 8'h09);
    wr(`CIC_SEL_CTRL_B, 8'h08);
    rd(`CIC_SEL_CNT_L, 8'h00);
    rd(`CIC_SEL_FLAGS, 8'h04);
    $display("test fast mode done");
    conclude();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    #(3000 * 100);
    miscompares++;
    conclude();
  end
endmodule // counter16_input_capture_bench
